// File: logic/memory_space_decoder_defines.vh
/*
 Address map constants for the memory space decoder and its size
 select registers.
 Assumes: included by the design files by bare name.
*/
`ifndef MEMORY_SPACE_DECODER_DEFINES_VH
`define MEMORY_SPACE_DECODER_DEFINES_VH

// Wishbone register byte offsets
`define REG_ROM_SIZE_OFS     4'h0
`define REG_XRAM_SIZE_OFS    4'h4
`define REG_CTRL_OFS         4'h8
`define REG_STATUS_OFS       4'hc

// Size select reset values and encodings
`define ROM_SIZE_RST         8'hcf
`define XRAM_SIZE_RST        8'h0c
`define ROM_SEL_24K          8'hc6
`define ROM_SEL_32K          8'hc8
`define ROM_SEL_48K          8'hcc
`define ROM_SEL_60K          8'hcf
`define XRAM_SEL_NONE        8'h0c
`define XRAM_SEL_1K          8'h0a
`define XRAM_SEL_2K          8'h08
`define XRAM_SEL_4K          8'h04

// Flash top addresses (exclusive) per size
`define ROM_TOP_24K          17'h06000
`define ROM_TOP_32K          17'h08000
`define ROM_TOP_48K          17'h0c000
`define ROM_TOP_60K          17'h0f000

// Expansion RAM bases, all ending at f7ff
`define XRAM_BASE_1K         16'hf400
`define XRAM_BASE_2K         16'hf000
`define XRAM_BASE_4K         16'he800
`define XRAM_END             16'hf7ff

// Fixed regions
`define VECT_END             16'h003f
`define TCALL_BASE           16'h0040
`define TCALL_END            16'h007f
`define OPT_BASE             16'h0080
`define OPT_END              16'h0084
`define SECID_BASE           16'h0085
`define SECID_END            16'h008e
`define BOOT_COPY_OFS        16'h1000
`define FCALL_BASE           16'h0800
`define FCALL_END            16'h0fff
`define BOOT0_END            16'h0fff
`define BANK_BASE            16'h8000
`define BANK_END             16'hbfff
`define HSRAM_BASE           16'hfb00
`define HSRAM_END            16'hfeff
`define REGBANK_BASE         16'hfee0
`define PERIPH_BASE          16'hff00

// Vector addresses
`define VEC_RESET            16'h0000
`define VEC_LOW_VOLT         16'h0004
`define VEC_PIN0             16'h0006
`define VEC_PIN1             16'h0008
`define VEC_PIN5             16'h0010
`define VEC_BREAK            16'h003e

// Control register bit positions
`define CTRL_BANK_LO         0
`define CTRL_BANK_HI         1
`define CTRL_BOOT_LOCK       2
`define CTRL_BANKED          3
`define CTRL_ANALOG          4

`endif

// File: logic/vector_store.v
/*
 Little vector memory: 32 words of 16 bits, one per vector slot of the
 vector table. Written a byte at a time, read data registered.
 Assumes: single clock, byte address with bit 0 as byte select.
*/
`timescale 1ns/100ps
`default_nettype none
module vector_store (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // Byte write port
  input  wire        wr_en,
  input  wire [5:0]  wr_addr,
  input  wire [7:0]  wr_data,
  // Word read port
  input  wire [4:0]  rd_slot,
  output reg  [15:0] rd_word_q
);

  reg [7:0] lo_mem [0:31];
  reg [7:0] hi_mem [0:31];

  always @(posedge sys_clk)
  begin
    if (wr_en && !wr_addr[0])
      lo_mem[wr_addr[5:1]] <= wr_data;
    if (wr_en && wr_addr[0])
      hi_mem[wr_addr[5:1]] <= wr_data;
  end

  // Low byte from even, high byte from odd address
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_word_q <= 16'h0000;
    else
      rd_word_q <= {hi_mem[rd_slot], lo_mem[rd_slot]}; // R10
  end

endmodule // vector_store
`default_nettype wire

// File: logic/region_select.v
/*
 Combinational region decode of one 16-bit address against the
 current size settings and the bank page.
 Assumes: size codes come from registers; outputs are registered downstream.
*/
`timescale 1ns/100ps
`default_nettype none
`include "memory_space_decoder_defines.vh"
module region_select (
  // Address and configuration
  input  wire [15:0] addr,
  input  wire [7:0]  rom_size_select,
  input  wire [7:0]  expansion_ram_size_select,
  input  wire        banked,
  input  wire [1:0]  bank_page,
  // Region strobes
  output reg         sel_flash,
  output reg         sel_xram,
  output reg         sel_hsram,
  output reg         sel_periph,
  output reg  [17:0] flash_addr
);

  function [16:0] rom_top;
    input [7:0] code;
    begin
      case (code)
        `ROM_SEL_24K: rom_top = `ROM_TOP_24K;
        `ROM_SEL_32K: rom_top = `ROM_TOP_32K;
        `ROM_SEL_48K: rom_top = `ROM_TOP_48K;
        `ROM_SEL_60K: rom_top = `ROM_TOP_60K;
        default:      rom_top = 17'h00000; // R25
      endcase
    end
  endfunction

  function [16:0] xram_base;
    input [7:0] code;
    begin
      case (code)
        `XRAM_SEL_1K: xram_base = {1'b0, `XRAM_BASE_1K};
        `XRAM_SEL_2K: xram_base = {1'b0, `XRAM_BASE_2K};
        `XRAM_SEL_4K: xram_base = {1'b0, `XRAM_BASE_4K}; // R22
        default:      xram_base = 17'h10000; // R25
      endcase
    end
  endfunction

  always @*
  begin
    sel_flash  = ({1'b0, addr} < rom_top(rom_size_select)); // R5 R1
    sel_xram   = ({1'b0, addr} >= xram_base(expansion_ram_size_select))
                 && (addr <= `XRAM_END); // R6
    sel_hsram  = (addr >= `HSRAM_BASE) && (addr <= `HSRAM_END); // R21
    sel_periph = (addr >= `PERIPH_BASE); // R23
    flash_addr = {2'b00, addr};
    if (banked && addr >= `BANK_BASE && addr <= `BANK_END)
      flash_addr = {bank_page, 2'b10, addr[13:0]}; // R8 R7
  end

endmodule // region_select
`default_nettype wire

// File: logic/memory_space_decoder.v
/*
 Memory space decoder: size select registers, region decode for the
 core's fetch and data path, vector fetch and boot write protection.
 Assumes: classic Wishbone slave on sys_clk; the core holds its
 request until it sees its answer one cycle later.
*/
// Notes on behaviour
// R1: One flat 64 KB space decoded for fetch and data alike.
// R2: Size registers reset to cf and 0c on every variant.
// R3: Software writes the ROM size before the expansion RAM size.
// R4: Software keeps ROM and expansion RAM regions from overlapping.
// R5: ROM codes c6, c8, cc, cf give 24, 32, 48, 60 KB.
// R6: RAM codes 0c, 0a, 08, 04 give none, 1, 2, 4 KB.
// R7: Banked part uses the 48 KB code and reaches more through banks.
// R8: Banked flash: common 0000-7fff, four 16 KB pages at 8000-bfff.
// R9: Vector table fills 0000 to 003f.
// R10: Vector low byte at even address, high byte at next odd.
// R11: All reset sources use vector 0000; break uses 003e.
// R12: Low-voltage interrupt uses 0004; pin interrupt 0 uses 0006.
// R13: Pin interrupts 1 to 4 use 0008-000e; pin 5 uses 0010.
// R14: 0040 to 007f hold table-call entry addresses.
// R15: Option bytes at 0080-0084, copy at 1080-1084 with boot swap.
// R16: Debug security ID at 0085-008e, copy at 1085-108e with swap.
// R17: 0800 to 0fff reachable as far-area call targets.
// R18: Writes to boot cluster 0 can be blocked by security setting.
// R19: Port 2 analog pins default to analog mode after reset.
// R20: Fetches are addressed by the program counter.
// R21: High-speed RAM at fb00-feff, top 32 bytes are register banks.
// R22: 4 KB expansion RAM at e800-f7ff; smaller sizes start higher.
// R23: ff00 to ffff go to the peripheral register area.
// R24: On reset the program counter loads from 0000 and 0001.
// R25: Addresses outside selected sizes select no internal array.
`timescale 1ns/100ps
`default_nettype none
`include "memory_space_decoder_defines.vh"
module memory_space_decoder (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Core access path
  input  wire        core_req,
  input  wire        core_we,
  input  wire        core_fetch,
  input  wire [15:0] core_addr,
  input  wire [15:0] core_pc,
  input  wire [7:0]  core_wdata,
  // Vector requests
  input  wire        reset_fetch,
  input  wire        power_on_clear,
  input  wire        low_voltage_detector,
  input  wire        watchdog_reset_source,
  input  wire        low_voltage_irq,
  input  wire        software_break,
  input  wire [5:0]  pin_irq,
  // Region selects to the arrays
  output reg         flash_sel_q,
  output reg  [17:0] flash_addr_q,
  output reg         flash_we_q,
  output reg         xram_sel_q,
  output reg         hsram_sel_q,
  output reg         regbank_q,
  output reg         periph_sel_q,
  output reg  [15:0] mem_addr_q,
  output reg         mem_we_q,
  output reg  [7:0]  mem_wdata_q,
  output reg  [3:0]  area_q,
  output reg         write_blocked_q,
  // Vector result
  output reg         vector_valid_q,
  output reg  [15:0] vector_q,
  output reg         pc_load_q,
  // Pin mode
  output reg  [7:0]  port2_analog_pins
);

  localparam AREA_NONE  = 4'h0;
  localparam AREA_VECT  = 4'h1;
  localparam AREA_TCALL = 4'h2;
  localparam AREA_OPT   = 4'h3;
  localparam AREA_SECID = 4'h4;
  localparam AREA_FCALL = 4'h5;
  localparam AREA_FLASH = 4'h6;

  localparam V_IDLE = 2'd0;
  localparam V_READ = 2'd1;
  localparam V_DONE = 2'd2;

  ////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0]  rom_size_q;
  reg  [7:0]  xram_size_q;
  reg  [4:0]  ctrl_q;
  reg  [1:0]  vst_q;
  reg  [4:0]  vslot_q;
  reg         vreset_q;
  reg  [3:0]  area_d;
  reg  [4:0]  slot_d;
  reg         vreq_d;

  wire        wb_hit     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr      = wb_hit && wb_we_i && wb_sel_i[0];
  wire [15:0] acc_addr   = core_fetch ? core_pc : core_addr; // R20 R1
  wire        sel_flash;
  wire        sel_xram;
  wire        sel_hsram;
  wire        sel_periph;
  wire [17:0] sel_faddr;
  wire [15:0] vword;
  wire        flash_we_ok = !(ctrl_q[`CTRL_BOOT_LOCK]); // R18

  // Copy at offset 1000 is always decoded too, whether or not boot swap is in use
  function in_span;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_span = (a >= lo && a <= hi)
        || (a >= lo + `BOOT_COPY_OFS && a <= hi + `BOOT_COPY_OFS);
    end
  endfunction

  function [4:0] vec_slot;
    input [15:0] a;
    begin
      vec_slot = a[5:1];
    end
  endfunction

  // Size registers; order and overlap are software's duty (R3, R4)
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rom_size_q  <= `ROM_SIZE_RST; // R2
      xram_size_q <= `XRAM_SIZE_RST; // R2
      ctrl_q      <= 5'h10;
    end
    else if (wb_wr)
    begin
      case (wb_adr_i)
        `REG_ROM_SIZE_OFS:  rom_size_q  <= wb_dat_i[7:0];
        `REG_XRAM_SIZE_OFS: xram_size_q <= wb_dat_i[7:0];
        `REG_CTRL_OFS:      ctrl_q      <= wb_dat_i[4:0];
        default:            ctrl_q      <= ctrl_q;
      endcase
    end
  end

  // One wait-free answer; unmapped reads return zero
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      case (wb_adr_i)
        `REG_ROM_SIZE_OFS:  wb_dat_o <= {24'h000000, rom_size_q};
        `REG_XRAM_SIZE_OFS: wb_dat_o <= {24'h000000, xram_size_q};
        `REG_CTRL_OFS:      wb_dat_o <= {27'h0000000, ctrl_q};
        `REG_STATUS_OFS:    wb_dat_o <= {16'h0000, vector_q};
        default:            wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Region decode

  region_select u_region (
    .addr                      (acc_addr),
    .rom_size_select           (rom_size_q),
    .expansion_ram_size_select (xram_size_q),
    .banked                    (ctrl_q[`CTRL_BANKED]),
    .bank_page                 (ctrl_q[`CTRL_BANK_HI:`CTRL_BANK_LO]),
    .sel_flash                 (sel_flash),
    .sel_xram                  (sel_xram),
    .sel_hsram                 (sel_hsram),
    .sel_periph                (sel_periph),
    .flash_addr                (sel_faddr)
  );

  always @*
  begin
    area_d = AREA_NONE;
    if (!sel_flash)
      area_d = AREA_NONE;
    else if (acc_addr <= `VECT_END)
      area_d = AREA_VECT; // R9
    else if (acc_addr >= `TCALL_BASE && acc_addr <= `TCALL_END)
      area_d = AREA_TCALL; // R14
    else if (in_span(acc_addr, `OPT_BASE, `OPT_END))
      area_d = AREA_OPT; // R15
    else if (in_span(acc_addr, `SECID_BASE, `SECID_END))
      area_d = AREA_SECID; // R16
    else if (acc_addr >= `FCALL_BASE && acc_addr <= `FCALL_END)
      area_d = AREA_FCALL; // R17
    else
      area_d = AREA_FLASH;
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flash_sel_q     <= 1'b0;
      flash_addr_q    <= 18'h00000;
      flash_we_q      <= 1'b0;
      xram_sel_q      <= 1'b0;
      hsram_sel_q     <= 1'b0;
      regbank_q       <= 1'b0;
      periph_sel_q    <= 1'b0;
      mem_addr_q      <= 16'h0000;
      mem_we_q        <= 1'b0;
      mem_wdata_q     <= 8'h00;
      area_q          <= 4'h0;
      write_blocked_q <= 1'b0;
    end
    else
    begin
      flash_sel_q  <= core_req && sel_flash; // R25
      flash_addr_q <= sel_faddr; // R8
      flash_we_q   <= core_req && core_we && sel_flash
        && !(ctrl_q[`CTRL_BOOT_LOCK] && acc_addr <= `BOOT0_END); // R18
      write_blocked_q <= core_req && core_we && sel_flash
        && ctrl_q[`CTRL_BOOT_LOCK] && acc_addr <= `BOOT0_END; // R18
      xram_sel_q   <= core_req && sel_xram && !sel_flash; // R22 R25
      hsram_sel_q  <= core_req && sel_hsram; // R21
      regbank_q    <= core_req && acc_addr >= `REGBANK_BASE
                      && acc_addr <= `HSRAM_END; // R21
      periph_sel_q <= core_req && sel_periph; // R23
      mem_addr_q   <= acc_addr;
      mem_we_q     <= core_req && core_we;
      mem_wdata_q  <= core_wdata;
      area_q       <= core_req ? area_d : AREA_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Vector fetch

  // Reset sources win, then break, low-voltage, pin 0, pin 5, then pins 1 to 4 in order
  always @*
  begin
    vreq_d = 1'b1;
    slot_d = 5'd0;
    if (reset_fetch || power_on_clear || low_voltage_detector
        || watchdog_reset_source)
      slot_d = vec_slot(`VEC_RESET); // R11 R24
    else if (software_break)
      slot_d = vec_slot(`VEC_BREAK); // R11
    else if (low_voltage_irq)
      slot_d = vec_slot(`VEC_LOW_VOLT); // R12
    else if (pin_irq[0])
      slot_d = vec_slot(`VEC_PIN0); // R12
    else if (pin_irq[5])
      slot_d = vec_slot(`VEC_PIN5); // R13
    else if (pin_irq[1])
      slot_d = vec_slot(`VEC_PIN1); // R13
    else if (pin_irq[2])
      slot_d = vec_slot(`VEC_PIN1) + 5'd1; // R13
    else if (pin_irq[3])
      slot_d = vec_slot(`VEC_PIN1) + 5'd2; // R13
    else if (pin_irq[4])
      slot_d = vec_slot(`VEC_PIN1) + 5'd3; // R13
    else
      vreq_d = 1'b0;
  end

  vector_store u_vectors (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .wr_en     (core_req && core_we && sel_flash && acc_addr <= `VECT_END
                && flash_we_ok),
    .wr_addr   (acc_addr[5:0]),
    .wr_data   (core_wdata),
    .rd_slot   (vslot_q),
    .rd_word_q (vword)
  );

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vst_q          <= V_IDLE;
      vslot_q        <= 5'd0;
      vreset_q       <= 1'b0;
      vector_valid_q <= 1'b0;
      vector_q       <= 16'h0000;
      pc_load_q      <= 1'b0;
    end
    else
    begin
      vector_valid_q <= 1'b0;
      pc_load_q      <= 1'b0;
      case (vst_q)
        V_IDLE:
        begin
          if (vreq_d)
          begin
            vslot_q  <= slot_d;
            vreset_q <= (slot_d == 5'd0);
            vst_q    <= V_READ;
          end
        end
        V_READ:
          vst_q <= V_DONE;
        V_DONE:
        begin
          vector_q       <= vword; // R10
          vector_valid_q <= 1'b1;
          pc_load_q      <= vreset_q; // R24
          vst_q          <= V_IDLE;
        end
        default:
          vst_q <= V_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Port 2 mode: analog after reset, software may switch to digital

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      port2_analog_pins <= 8'hff; // R19
    else
      port2_analog_pins <= {8{ctrl_q[`CTRL_ANALOG]}}; // R19
  end

endmodule // memory_space_decoder
`default_nettype wire

// File: bench/memory_space_decoder_checker.sv
/*
 Checker for the decoder's address map, boot lock and reset vector.
 Assumes: bound to memory_space_decoder; one clock, reset low.
*/
`timescale 1ns/100ps
`default_nettype none
module memory_space_decoder_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // Core side
  input wire logic        core_req,
  input wire logic        core_we,
  input wire logic        core_fetch,
  input wire logic [15:0] core_addr,
  input wire logic [15:0] core_pc,
  // Reset sources
  input wire logic        reset_fetch,
  input wire logic        power_on_clear,
  input wire logic        low_voltage_detector,
  input wire logic        watchdog_reset_source,
  // Decoder outputs
  input wire logic        flash_sel_q,
  input wire logic        flash_we_q,
  input wire logic        xram_sel_q,
  input wire logic        hsram_sel_q,
  input wire logic        regbank_q,
  input wire logic        periph_sel_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic [3:0]  area_q,
  input wire logic        write_blocked_q,
  input wire logic        vector_valid_q,
  input wire logic        pc_load_q,
  input wire logic [7:0]  port2_analog_pins
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  logic rst_any;
  assign rst_any = reset_fetch | power_on_clear | low_voltage_detector | watchdog_reset_source;
  ////////////////////////////////////////
  // Writes are left out: a locked write may be reported differently
  sequence data_rd(lo, hi);
    core_req && !core_we && !core_fetch && core_addr >= lo && core_addr <= hi;
  endsequence
  AST_VECT_AREA: assert property (data_rd(16'h0000, 16'h003f) |=> area_q == 4'h1)
    else $error("vector table read not marked");
  AST_TCALL_AREA: assert property (data_rd(16'h0040, 16'h007f) |=> area_q == 4'h2)
    else $error("table call read not marked");
  AST_OPT_AREA: assert property (data_rd(16'h0080, 16'h0084) |=> area_q == 4'h3)
    else $error("option byte read not marked");
  AST_SECID_AREA: assert property (data_rd(16'h0085, 16'h008e) |=> area_q == 4'h4)
    else $error("security id read not marked");
  AST_FCALL_AREA: assert property (data_rd(16'h0800, 16'h0fff) |=> area_q == 4'h5)
    else $error("far call read not marked");
  AST_HSRAM: assert property (data_rd(16'hfb00, 16'hfeff) |=> hsram_sel_q && !periph_sel_q)
    else $error("high speed ram not selected");
  AST_REGBANK: assert property (regbank_q |-> hsram_sel_q && mem_addr_q[15:5] == 11'h7f7)
    else $error("register bank outside top 32 bytes");
  AST_PERIPH: assert property (data_rd(16'hff00, 16'hffff) |=> periph_sel_q && !flash_sel_q)
    else $error("peripheral area not selected");
  AST_FETCH_PC: assert property (core_req && core_fetch |=> mem_addr_q == $past(core_pc))
    else $error("fetch not addressed by pc");
  AST_XRAM_SPAN: assert property (xram_sel_q |-> !flash_sel_q && mem_addr_q >= 16'he800 && mem_addr_q <= 16'hf7ff)
    else $error("expansion ram selected out of span");
  AST_BOOT_BLOCK: assert property (write_blocked_q |-> !flash_we_q && mem_addr_q <= 16'h0fff)
    else $error("blocked write reached flash");
  AST_ANALOG: assert property ($rose(arst_n) |-> port2_analog_pins == 8'hff)
    else $error("port 2 pins not analog after reset");
  AST_RST_VEC: assert property (pc_load_q |-> vector_valid_q && $past(rst_any, 3))
    else $error("pc load without reset source");
endmodule // memory_space_decoder_checker

bind memory_space_decoder memory_space_decoder_checker u_checker (
  .sys_clk(sys_clk), .arst_n(arst_n), .core_req(core_req), .core_we(core_we),
  .core_fetch(core_fetch), .core_addr(core_addr), .core_pc(core_pc),
  .reset_fetch(reset_fetch), .power_on_clear(power_on_clear),
  .low_voltage_detector(low_voltage_detector), .watchdog_reset_source(watchdog_reset_source),
  .flash_sel_q(flash_sel_q), .flash_we_q(flash_we_q), .xram_sel_q(xram_sel_q),
  .hsram_sel_q(hsram_sel_q), .regbank_q(regbank_q), .periph_sel_q(periph_sel_q),
  .mem_addr_q(mem_addr_q), .area_q(area_q), .write_blocked_q(write_blocked_q),
  .vector_valid_q(vector_valid_q), .pc_load_q(pc_load_q),
  .port2_analog_pins(port2_analog_pins)
);
`default_nettype wire

// File: bench/core_port_model.sv
/*
 Core side model: one byte access or fetch per call.
 Assumes: called from the bench; accesses taken one edge after set.
*/
`timescale 1ns/100ps
`default_nettype none
module core_port_model (
  // Clock
  input  wire logic        sys_clk,
  // Core access path
  output var  logic        core_req,
  output var  logic        core_we,
  output var  logic        core_fetch,
  output var  logic [15:0] core_addr,
  output var  logic [15:0] core_pc,
  output var  logic [7:0]  core_wdata
);
  initial
  begin
    core_req = 1'b0;
    core_we = 1'b0;
    core_fetch = 1'b0;
    core_addr = 16'h0000;
    core_pc = 16'h0000;
    core_wdata = 8'h00;
  end
  ////////////////////////////////////////
  // Unused address lines carry junk so a wrong source shows up
  task access(input logic f, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    core_req <= 1'b1;
    core_fetch <= f;
    core_we <= w;
    core_addr <= f ? ~a : a;
    core_pc <= f ? a : ~a;
    core_wdata <= d;
    @(posedge sys_clk);
    core_req <= 1'b0;
    core_addr <= ~a;
    core_pc <= ~a;
    core_wdata <= ~d;
    #1;
  endtask
endmodule // core_port_model
`default_nettype wire

// File: bench/memory_space_decoder_tb.sv
/*
 Self-checking bench for the memory space decoder.
 Assumes: defines on the include path; core side driven by core_port_model.
*/
`timescale 1ns/100ps
`default_nettype none
module memory_space_decoder_tb;
  logic        sys_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i, area_q;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        core_req, core_we, core_fetch, flash_sel_q, flash_we_q, xram_sel_q;
  logic        hsram_sel_q, regbank_q, periph_sel_q, mem_we_q, write_blocked_q;
  logic        vector_valid_q, pc_load_q;
  logic [15:0] core_addr, core_pc, mem_addr_q, vector_q;
  logic [7:0]  core_wdata, mem_wdata_q, port2_analog_pins;
  logic [11:0] src;
  logic [17:0] flash_addr_q;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [15:0] vaddr [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h003e,
                              16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010};
  memory_space_decoder dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_req(core_req), .core_we(core_we),
    .core_fetch(core_fetch), .core_addr(core_addr), .core_pc(core_pc),
    .core_wdata(core_wdata), .reset_fetch(src[0]), .power_on_clear(src[1]),
    .low_voltage_detector(src[2]), .watchdog_reset_source(src[3]),
    .low_voltage_irq(src[4]), .software_break(src[5]), .pin_irq(src[11:6]),
    .flash_sel_q(flash_sel_q), .flash_addr_q(flash_addr_q), .flash_we_q(flash_we_q),
    .xram_sel_q(xram_sel_q), .hsram_sel_q(hsram_sel_q), .regbank_q(regbank_q),
    .periph_sel_q(periph_sel_q), .mem_addr_q(mem_addr_q), .mem_we_q(mem_we_q),
    .mem_wdata_q(mem_wdata_q), .area_q(area_q), .write_blocked_q(write_blocked_q),
    .vector_valid_q(vector_valid_q), .vector_q(vector_q), .pc_load_q(pc_load_q),
    .port2_analog_pins(port2_analog_pins));
  core_port_model core (
    .sys_clk(sys_clk), .core_req(core_req), .core_we(core_we), .core_fetch(core_fetch),
    .core_addr(core_addr), .core_pc(core_pc), .core_wdata(core_wdata));
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    chk(n < 20, 1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task acc(input logic [15:0] a);
    core.access(1'b0, 1'b0, a, 8'h00);
  endtask
  // Requests are levels held until the vector comes back
  task vec(input int i);
    int n;
    logic [7:0] a;
    a = vaddr[i][7:0];
    @(posedge sys_clk);
    src <= 12'h001 << i;
    n = 0;
    while (vector_valid_q !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(vector_valid_q, 1);
    chk(vector_q, {8'h80 | a | 8'h01, a});
    chk(pc_load_q, i < 4);
    @(posedge sys_clk);
    src <= 12'h000;
    // Held level rearms once; let that repeat fetch pass
    repeat (4) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////
  task t_reset();
    rd(4'h0, 32'hcf);
    rd(4'h4, 32'h0c);
    chk(port2_analog_pins, 8'hff);
    wr(4'h2, 32'hff);
    rd(4'h2, 32'h0);
  endtask
  task t_rom();
    logic [7:0]  c [4] = '{8'hc6, 8'hc8, 8'hcc, 8'hcf};
    logic [15:0] t [4] = '{16'h6000, 16'h8000, 16'hc000, 16'hf000};
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h0, {24'h0, c[i]});
      rd(4'h0, {24'h0, c[i]});
      acc(t[i] - 16'h0001);
      chk(flash_sel_q, 1);
      acc(t[i]);
      chk(flash_sel_q, 0);
    end
  endtask
  task t_xram();
    logic [7:0]  c [4] = '{8'h0c, 8'h0a, 8'h08, 8'h04};
    logic [15:0] b [4] = '{16'hf800, 16'hf400, 16'hf000, 16'he800};
    wr(4'h0, 32'hc6);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h4, {24'h0, c[i]});
      acc(b[i] - 16'h0001);
      chk(xram_sel_q, 0);
      acc(b[i]);
      chk(xram_sel_q, i > 0);
      acc(16'hf7ff);
      chk(xram_sel_q, i > 0);
    end
  endtask
  task t_bank();
    wr(4'h0, 32'hcc);
    for (int p = 0; p < 4; p++)
    begin
      wr(4'h8, 32'h8 | p);
      acc(16'h9234);
      chk(flash_addr_q, {p[1:0], 2'b10, 14'h1234});
    end
    acc(16'h7fff);
    chk(flash_addr_q, 18'h07fff);
    acc(16'hc000);
    chk(flash_sel_q, 0);
  endtask
  task t_areas();
    logic [15:0] a [6] = '{16'h0002, 16'h0041, 16'h0081, 16'h0086, 16'h0900, 16'h2000};
    for (int i = 0; i < 6; i++)
    begin
      acc(a[i]);
      chk(area_q, i + 1);
    end
    core.access(1'b1, 1'b0, 16'h0042, 8'h00);
    chk(mem_addr_q, 16'h0042);
    acc(16'hfb00);
    chk(hsram_sel_q, 1);
    acc(16'hfee5);
    chk(regbank_q, 1);
    acc(16'hff10);
    chk(periph_sel_q, 1);
  endtask
  task t_vec();
    wr(4'h8, 32'h10);
    for (int k = 0; k < 64; k++)
      core.access(1'b0, 1'b1, k[15:0], k[0] ? 8'h80 | k[7:0] : k[7:0]);
    for (int i = 0; i < 12; i++)
      vec(i);
  endtask
  task t_lock();
    wr(4'h8, 32'h14);
    core.access(1'b0, 1'b1, 16'h0010, 8'h55);
    chk(write_blocked_q, 1);
    chk(flash_we_q, 0);
    core.access(1'b0, 1'b1, 16'h1010, 8'h55);
    chk(flash_we_q, 1);
    vec(11);
  endtask
  task summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    src = 12'h000;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_rom();
    t_xram();
    t_bank();
    t_areas();
    t_vec();
    t_lock();
    summarize();
  end
  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule // memory_space_decoder_tb
`default_nettype wire
